// [logic/compressor_speed_pkg.sv]
package compressor_speed_pkg;
  // Holding-register numbers on the fieldbus
  localparam logic [8:0] ADR_RUN_ENABLE = 9'h064;
  localparam logic [8:0] ADR_SPEED_DEMAND = 9'h065;
  localparam logic [8:0] ADR_HEAT_DEMAND = 9'h066;
  localparam logic [8:0] ADR_FAULT_CLEAR = 9'h067;
  localparam logic [8:0] ADR_MIN_SPEED = 9'h06D;
  localparam logic [8:0] ADR_ENV_MODE = 9'h0E7;
  localparam logic [8:0] ADR_ALARM = 9'h033;
  localparam logic [8:0] ADR_HEAT_LIMIT = 9'h034;
  localparam logic [8:0] ADR_SUB_MIN = 9'h02C;
  localparam logic [8:0] ADR_SUB_MAX = 9'h02D;
  localparam logic [8:0] ADR_OUT_REMAIN = 9'h02F;
  localparam logic [8:0] ADR_SHUT_RATE = 9'h0D2;
  localparam logic [8:0] ADR_ACCEL = 9'h0D3;
  localparam logic [8:0] ADR_DECEL = 9'h0D4;
  localparam logic [8:0] ADR_PLATFORM = 9'h0D5;
  localparam logic [8:0] ADR_HOLD_TIME = 9'h0EA;
  localparam logic [8:0] ADR_ZONE_A = 9'h13E;
  localparam logic [8:0] ADR_ZONE_B = 9'h13F;
  localparam logic [8:0] ADR_ZONE_C = 9'h140;
  localparam logic [8:0] ADR_ZONE_D = 9'h141;
  // Reset values
  localparam logic [15:0] RST_RATE = 16'h00C8;
  localparam logic [15:0] RST_PLATFORM = 16'h0E10;
  localparam logic [15:0] RST_HOLD_S = 16'h0078;
  // Rate limits and fixed profile figures, rpm and rpm/s
  localparam logic [15:0] RATE_MAX = 16'h0258;
  localparam logic [15:0] SHUT_RATE_MIN = 16'h001E;
  localparam logic [15:0] STAGE1_RATE = 16'h0258;
  localparam logic [15:0] STAGE2_RATE = 16'h03E8;
  localparam logic [15:0] FAST_STOP_RATE = 16'h04B0;
  localparam logic [15:0] STAGE1_END = 16'h05DC;
  localparam logic [15:0] OUT_ENV_MIN = 16'h0A28;
  localparam logic [15:0] OUT_ENV_MAX = 16'h1770;
  localparam logic [15:0] PASSIVE_MAX = 16'h1770;
  // Envelope timing in seconds, grey-zone temperature split in degC
  localparam logic [15:0] WHITE_LIMIT_S = 16'h001E;
  localparam logic [15:0] GREY_COLD_S = 16'h0384;
  localparam logic [15:0] GREY_WARM_S = 16'h0708;
  localparam logic [15:0] GREY_TEMP_C = 16'hFFF1;
  localparam logic [15:0] ALARM_DELAY_S = 16'h000F;
  localparam logic [15:0] FAULT_WAIT_S = 16'h001E;
  localparam int ALARM_BIT = 12;
  localparam logic [1:0] MODE_ACTIVE = 2'h3;
  localparam logic [15:0] MODE_MAX = 16'h0003;
  // Heating quantisation
  localparam logic [15:0] HEAT_STEP = 16'h000A;
  localparam logic [15:0] HEAT_MAX = 16'h0064;
  localparam logic [15:0] HEAT_FULL = 16'h0096;
  // Passive current curve: threshold = base + speed / 2^shift
  localparam logic [15:0] CUR_BASE = 16'h0100;
  localparam int CUR_SHIFT = 4;
  // Timebase
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES_DFLT = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICKS_PER_S = 1_000_000 / TICK_US;
  localparam logic [23:0] MILLI = 24'h0003E8;
  // Sub-region limits, index 0..5
  localparam logic [5:0][15:0] SUB_MIN_TBL = {16'h0BB8, 16'h0A28, 16'h0A28,
    16'h0708, 16'h05DC, 16'h0708};
  localparam logic [5:0][15:0] SUB_MAX_TBL = {16'h1770, 16'h1770, 16'h1388,
    16'h1388, 16'h1194, 16'h0FA0};
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_HEAT = 7'h02,
    ST_RAMP1 = 7'h04,
    ST_RAMP2 = 7'h08,
    ST_HOLD = 7'h10,
    ST_RUN = 7'h20,
    ST_CSTOP = 7'h40
  } run_state_t;
endpackage : compressor_speed_pkg

// [logic/compressor_speed_sequencer.sv]
`timescale 1ns/1ps
// Contract
// - Any nonzero heating demand write enters stator heating; no separate switch.
// - Nonzero heating demand rounds up to next multiple of ten percent.
// - Stator power is 150 times rounded percent over 100; limit readable.
// - Run request beats heating and ends heating in progress.
// - Envelope mode register holds one of four codes, zero to three.
// - Passive modes fold back when current exceeds speed-derived threshold.
// - Mode 0: normal minimum and fold-back speed both the stored minimum.
// - Mode 1: operating-point minimum normally, stored minimum in fold-back.
// - Mode 2: controller-written minimum serves normal and fold-back speed.
// - Mode 3: outside envelope fifteen seconds sets alarm bit twelve.
// - White zone limit 30 s; grey 15 min below -15 C, else 30.
// - Outside envelope, demand is clamped into 2600 to 6000 rpm.
// - Remaining outside time and four zone thresholds are readable.
// - Active envelope mode forces discharge temperature guard on.
// - Inside envelope, publish the sub-region minimum and maximum speed.
// - Speed outside sub-region limits warns and is moved into limits.
// - Faults clear no sooner than 30 s; controller stops then clears.
// - Clear command clears gone causes and self-resets when none remain.
// - Start-up ramps to 1500 at 600 rpm/s, then platform at 1000.
// - Platform speed held for configured hold time; defaults 3600, 120 s.
// - Then ramp at accel/decel rates, default 200, above 600 refused.
// - Disable with demand nonzero stops at once; with zero, controlled.
// - Controlled stop: shutdown rate to platform, then over 1200 rpm/s.
module compressor_speed_sequencer
  import compressor_speed_pkg::*;
#(
  parameter int NUM_FAULTS = 4,
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port behind the fieldbus
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_q,
  // Plant and envelope inputs
  input wire logic [15:0] nv_min_speed,
  input wire logic [15:0] op_min_speed,
  input wire logic [15:0] out_current,
  input wire logic env_outside,
  input wire logic env_grey,
  input wire logic [2:0] subregion,
  input wire logic [15:0] evap_temp,
  input wire logic dlt_config,
  input wire logic [NUM_FAULTS-1:0] fault_cause,
  // Drive outputs
  output logic [15:0] speed_setpoint_q,
  output logic [15:0] stator_power_q,
  output logic heating_active_q,
  output logic running_q,
  output logic speed_drop_foldback_q,
  output logic speed_warning_q,
  output logic discharge_temp_guard_q,
  output logic fault_active_q
);
  localparam int NF = NUM_FAULTS + 1;

  if (NUM_FAULTS < 1 || NUM_FAULTS > 15 || TICK_CYCLES < 1
      || TICK_CYCLES > 32767) begin : g_bad_param
    $error("compressor_speed_sequencer: unsupported parameter value");
  end

  // Register file
  logic [15:0] run_enable_q, run_enable_d, demand_q, demand_d;
  logic [15:0] heat_q, heat_d, min_speed_q, min_speed_d;
  logic [15:0] shut_rate_q, shut_rate_d, accel_q, accel_d;
  logic [15:0] decel_q, decel_d, platform_q, platform_d, hold_q, hold_d;
  logic [1:0] mode_q, mode_d;
  logic clr_q, clr_d, nv_done_q, nv_done_d;
  logic [15:0] rdata_d;
  // Timebase and timers
  logic [14:0] tick_cnt_q, tick_cnt_d;
  logic [9:0] ms_cnt_q, ms_cnt_d, hold_ms_q, hold_ms_d;
  logic tick, sec;
  logic [15:0] hold_s_q, hold_s_d, out_s_q, out_s_d, fault_s_q, fault_s_d;
  // Sequencer
  run_state_t state_q, state_d;
  logic [23:0] spd_q, spd_d;
  logic [NF-1:0] fault_q, fault_d, cause_all;
  logic alarm_q, alarm_d;
  logic [15:0] power_d, spd_rpm, tgt, rate, lo, hi, fold_spd, cur_thr;
  logic [15:0] sub_min, sub_max, out_limit, remain;
  logic [23:0] tgt_m;
  logic [6:0] heat_steps;
  logic enable, run_req, fold, active, outside, trip, wr_heat;
  logic [15:0] clamp_dem;

  assign tick = (tick_cnt_q == 15'(TICK_CYCLES - 1));
  assign sec = tick && (ms_cnt_q == 10'(TICKS_PER_S - 1));
  assign spd_rpm = 16'(spd_q / MILLI);
  assign enable = run_enable_q[0];
  assign run_req = enable && (demand_q != 16'h0000);
  assign active = (mode_q == MODE_ACTIVE);
  assign outside = active && env_outside;
  assign wr_heat = reg_wr && (reg_addr == ADR_HEAT_DEMAND);
  assign cause_all = {trip, fault_cause};

  // Register writes and reads
  always_comb begin
    run_enable_d = run_enable_q;
    demand_d = demand_q;
    heat_d = heat_q;
    min_speed_d = min_speed_q;
    shut_rate_d = shut_rate_q;
    accel_d = accel_q;
    decel_d = decel_q;
    platform_d = platform_q;
    hold_d = hold_q;
    mode_d = mode_q;
    nv_done_d = 1'b1;
    // Nonvolatile minimum captured once after reset release
    if (!nv_done_q) begin
      min_speed_d = nv_min_speed;
    end
    // Auto-reset first so that a fresh write in the same cycle wins
    clr_d = clr_q && (fault_d != '0);
    if (reg_wr) begin
      unique case (reg_addr)
        ADR_RUN_ENABLE: run_enable_d = reg_wdata;
        ADR_SPEED_DEMAND: demand_d = reg_wdata;
        ADR_HEAT_DEMAND: heat_d = reg_wdata;
        ADR_FAULT_CLEAR: clr_d = reg_wdata[0];
        ADR_MIN_SPEED: min_speed_d = reg_wdata;
        ADR_ENV_MODE: begin
          if (reg_wdata <= MODE_MAX) begin
            mode_d = reg_wdata[1:0];
          end
        end
        ADR_SHUT_RATE: begin
          if (reg_wdata >= SHUT_RATE_MIN && reg_wdata <= RATE_MAX) begin
            shut_rate_d = reg_wdata;
          end
        end
        ADR_ACCEL: begin
          if (reg_wdata <= RATE_MAX) begin
            accel_d = reg_wdata;
          end
        end
        ADR_DECEL: begin
          if (reg_wdata <= RATE_MAX) begin
            decel_d = reg_wdata;
          end
        end
        ADR_PLATFORM: platform_d = reg_wdata;
        ADR_HOLD_TIME: hold_d = reg_wdata;
        default: ;
      endcase
    end
    rdata_d = reg_rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        ADR_RUN_ENABLE: rdata_d = run_enable_q;
        ADR_SPEED_DEMAND: rdata_d = demand_q;
        ADR_HEAT_DEMAND: rdata_d = heat_q;
        ADR_FAULT_CLEAR: rdata_d = {15'h0000, clr_q};
        ADR_MIN_SPEED: rdata_d = min_speed_q;
        ADR_ENV_MODE: rdata_d = {14'h0000, mode_q};
        ADR_ALARM: rdata_d = 16'(alarm_q) << ALARM_BIT;
        ADR_HEAT_LIMIT: rdata_d = HEAT_FULL;
        ADR_SUB_MIN: rdata_d = sub_min;
        ADR_SUB_MAX: rdata_d = sub_max;
        ADR_OUT_REMAIN: rdata_d = remain;
        ADR_SHUT_RATE: rdata_d = shut_rate_q;
        ADR_ACCEL: rdata_d = accel_q;
        ADR_DECEL: rdata_d = decel_q;
        ADR_PLATFORM: rdata_d = platform_q;
        ADR_HOLD_TIME: rdata_d = hold_q;
        ADR_ZONE_A: rdata_d = WHITE_LIMIT_S;
        ADR_ZONE_B: rdata_d = GREY_COLD_S;
        ADR_ZONE_C: rdata_d = GREY_WARM_S;
        ADR_ZONE_D: rdata_d = GREY_TEMP_C;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_enable_q <= 16'h0000;
      demand_q <= 16'h0000;
      heat_q <= 16'h0000;
      min_speed_q <= 16'h0000;
      shut_rate_q <= RST_RATE;
      accel_q <= RST_RATE;
      decel_q <= RST_RATE;
      platform_q <= RST_PLATFORM;
      hold_q <= RST_HOLD_S;
      mode_q <= 2'h0;
      clr_q <= 1'b0;
      nv_done_q <= 1'b0;
      reg_rdata_q <= 16'h0000;
    end else begin
      run_enable_q <= run_enable_d;
      demand_q <= demand_d;
      heat_q <= heat_d;
      min_speed_q <= min_speed_d;
      shut_rate_q <= shut_rate_d;
      accel_q <= accel_d;
      decel_q <= decel_d;
      platform_q <= platform_d;
      hold_q <= hold_d;
      mode_q <= mode_d;
      clr_q <= clr_d;
      nv_done_q <= nv_done_d;
      reg_rdata_q <= rdata_d;
    end
  end

  // Envelope evaluation and speed limits
  always_comb begin
    sub_min = SUB_MIN_TBL[(subregion > 3'h5) ? 3'h5 : subregion];
    sub_max = SUB_MAX_TBL[(subregion > 3'h5) ? 3'h5 : subregion];
    if (!env_grey) begin
      out_limit = WHITE_LIMIT_S;
    end else if ($signed(evap_temp) < $signed(GREY_TEMP_C)) begin
      out_limit = GREY_COLD_S;
    end else begin
      out_limit = GREY_WARM_S;
    end
    remain = (out_s_q >= out_limit) ? 16'h0000 : out_limit - out_s_q;
    trip = outside && running_q && (remain == 16'h0000);
    cur_thr = CUR_BASE + (spd_rpm >> CUR_SHIFT);
    fold = !active && running_q && (out_current > cur_thr);
    if (outside) begin
      lo = OUT_ENV_MIN;
      hi = OUT_ENV_MAX;
      fold_spd = OUT_ENV_MIN;
    end else if (active) begin
      lo = sub_min;
      hi = sub_max;
      fold_spd = sub_min;
    end else begin
      lo = (mode_q == 2'h1) ? op_min_speed : min_speed_q;
      hi = PASSIVE_MAX;
      fold_spd = min_speed_q;
    end
    if (demand_q < lo) begin
      clamp_dem = lo;
    end else if (demand_q > hi) begin
      clamp_dem = hi;
    end else begin
      clamp_dem = demand_q;
    end
    heat_steps = 7'((((heat_q > HEAT_MAX) ? HEAT_MAX : heat_q)
      + HEAT_STEP - 16'h0001) / HEAT_STEP);
    power_d = 16'(HEAT_FULL * 16'(heat_steps) * HEAT_STEP / HEAT_MAX);
    alarm_d = outside && (out_s_q >= ALARM_DELAY_S);
  end

  // Timebase and second counters
  always_comb begin
    tick_cnt_d = tick ? 15'h0000 : tick_cnt_q + 15'h0001;
    ms_cnt_d = ms_cnt_q;
    if (tick) begin
      ms_cnt_d = sec ? 10'h000 : ms_cnt_q + 10'h001;
    end
    out_s_d = outside ? out_s_q + 16'(sec && out_s_q != 16'hFFFF)
      : 16'h0000;
    // Own millisecond count: a free-running second would cut the hold short
    hold_ms_d = (state_q != ST_HOLD) ? 10'h000 : hold_ms_q + 10'(tick);
    if (tick && hold_ms_q == 10'(TICKS_PER_S - 1)) begin
      hold_ms_d = 10'h000;
    end
    hold_s_d = (state_q == ST_HOLD) ? hold_s_q
      + 16'(tick && hold_ms_q == 10'(TICKS_PER_S - 1)) : 16'h0000;
    // Set wins over clear; the wait restarts on every new fault
    fault_d = fault_q;
    for (int i = 0; i < NF; i++) begin
      if (clr_q && !cause_all[i] && fault_s_q > FAULT_WAIT_S) begin
        fault_d[i] = 1'b0;
      end
    end
    fault_d = fault_d | cause_all;
    if ((cause_all & ~fault_q) != '0) begin
      fault_s_d = 16'h0000;
    end else begin
      fault_s_d = fault_s_q + 16'(sec && fault_s_q != 16'hFFFF);
    end
  end

  // Run / heat sequencer
  always_comb begin
    state_d = state_q;
    tgt = 16'h0000;
    rate = FAST_STOP_RATE;
    unique case (state_q)
      ST_IDLE: begin
        if (run_req && fault_q == '0) begin
          state_d = ST_RAMP1;
        end else if (heat_q != 16'h0000 && fault_q == '0) begin
          state_d = ST_HEAT;
        end
      end
      ST_HEAT: begin
        if (run_req) begin
          state_d = ST_RAMP1;
        end else if (heat_q == 16'h0000 || fault_q != '0) begin
          state_d = ST_IDLE;
        end
      end
      ST_RAMP1: begin
        tgt = STAGE1_END;
        rate = STAGE1_RATE;
        if (spd_rpm >= STAGE1_END) begin
          state_d = ST_RAMP2;
        end
      end
      ST_RAMP2: begin
        tgt = platform_q;
        rate = STAGE2_RATE;
        if (spd_rpm == platform_q) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        tgt = platform_q;
        rate = STAGE2_RATE;
        if (hold_s_q >= hold_q) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        tgt = fold ? fold_spd : clamp_dem;
        rate = (tgt > spd_rpm) ? accel_q : decel_q;
      end
      ST_CSTOP: begin
        if (spd_rpm > platform_q) begin
          tgt = platform_q;
          rate = shut_rate_q;
        end else begin
          tgt = 16'h0000;
          rate = FAST_STOP_RATE;
        end
        if (spd_q == 24'h000000) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    if (state_q != ST_IDLE && state_q != ST_HEAT && state_q != ST_CSTOP) begin
      if (!enable && demand_q != 16'h0000) begin
        state_d = ST_IDLE;
      end else if (!enable) begin
        state_d = ST_CSTOP;
      end
    end
    if (fault_q != '0 && state_q != ST_HEAT) begin
      state_d = ST_IDLE;
    end
    tgt_m = 24'(tgt) * MILLI;
    spd_d = spd_q;
    if (state_d == ST_IDLE || state_d == ST_HEAT) begin
      spd_d = 24'h000000;
    end else if (tick && spd_q < tgt_m) begin
      spd_d = (tgt_m - spd_q > 24'(rate)) ? spd_q + 24'(rate) : tgt_m;
    end else if (tick && spd_q > tgt_m) begin
      spd_d = (spd_q - tgt_m > 24'(rate)) ? spd_q - 24'(rate) : tgt_m;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_q <= 15'h0000;
      ms_cnt_q <= 10'h000;
      hold_ms_q <= 10'h000;
      out_s_q <= 16'h0000;
      hold_s_q <= 16'h0000;
      fault_s_q <= 16'h0000;
      fault_q <= '0;
      state_q <= ST_IDLE;
      spd_q <= 24'h000000;
      alarm_q <= 1'b0;
      speed_setpoint_q <= 16'h0000;
      stator_power_q <= 16'h0000;
      heating_active_q <= 1'b0;
      running_q <= 1'b0;
      speed_drop_foldback_q <= 1'b0;
      speed_warning_q <= 1'b0;
      discharge_temp_guard_q <= 1'b0;
      fault_active_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      ms_cnt_q <= ms_cnt_d;
      hold_ms_q <= hold_ms_d;
      out_s_q <= out_s_d;
      hold_s_q <= hold_s_d;
      fault_s_q <= fault_s_d;
      fault_q <= fault_d;
      state_q <= state_d;
      spd_q <= spd_d;
      alarm_q <= alarm_d;
      speed_setpoint_q <= 16'(spd_d / MILLI);
      stator_power_q <= (state_d == ST_HEAT) ? power_d : 16'h0000;
      heating_active_q <= (state_d == ST_HEAT);
      running_q <= (state_d != ST_IDLE && state_d != ST_HEAT);
      speed_drop_foldback_q <= fold && state_d == ST_RUN;
      speed_warning_q <= active && state_q == ST_RUN
        && (spd_rpm < lo || spd_rpm > hi);
      discharge_temp_guard_q <= dlt_config || active;
      fault_active_q <= (fault_d != '0);
    end
  end

  sequence s_disable_live;
    running_q && state_q != ST_CSTOP && !enable && demand_q != 16'h0000
      && fault_q == '0;
  endsequence
  sequence s_stopped;
    !running_q && speed_setpoint_q == 16'h0000;
  endsequence
  a_immediate_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_disable_live |=> s_stopped)
    else $error("disable with demand did not stop at once");
  a_run_beats_heat: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_q == ST_HEAT && run_req |=> state_q == ST_RAMP1)
    else $error("run did not end heating");
  a_heat_power: assert property (@(posedge clk_sys) disable iff (!rstn)
    heating_active_q |-> stator_power_q <= HEAT_FULL
      && stator_power_q % 16'h000F == 16'h0000)
    else $error("stator power off the ten percent grid");
  a_mode_legal: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_wr && reg_addr == ADR_ENV_MODE && reg_wdata > MODE_MAX
      |=> $stable(mode_q))
    else $error("illegal envelope mode accepted");
  a_rate_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_wr && reg_addr == ADR_ACCEL && reg_wdata > RATE_MAX
      |=> accel_q == $past(accel_q))
    else $error("accel rate above limit accepted");
  a_alarm_delay: assert property (@(posedge clk_sys) disable iff (!rstn)
    alarm_q |-> $past(outside) && $past(out_s_q) >= ALARM_DELAY_S)
    else $error("alarm without fifteen seconds outside");
  a_dlt_forced: assert property (@(posedge clk_sys) disable iff (!rstn)
    active ##1 active |-> discharge_temp_guard_q)
    else $error("discharge guard off in active mode");
  a_fault_wait: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(fault_active_q) |-> $past(fault_s_q, 2) >= FAULT_WAIT_S)
    else $error("fault cleared before thirty seconds");
  a_clear_self: assert property (@(posedge clk_sys) disable iff (!rstn)
    clr_q && !fault_active_q && !(reg_wr && reg_addr == ADR_FAULT_CLEAR)
      ##1 !(reg_wr && reg_addr == ADR_FAULT_CLEAR) |-> !clr_q)
    else $error("clear command not reset after faults gone");
  a_ramp_step: assert property (@(posedge clk_sys) disable iff (!rstn)
    !tick && $past(!tick) && state_q == ST_RAMP1 && $past(state_q) == ST_RAMP1
      |-> $stable(spd_q))
    else $error("speed moved between ticks");
endmodule : compressor_speed_sequencer

// [dv/fieldbus_ctrl.sv]
`timescale 1ns/1ps
module fieldbus_ctrl
  import compressor_speed_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register requests
  output logic reg_wr,
  output logic reg_rd,
  output logic [8:0] reg_addr,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // Released data never keeps the last word
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [8:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  // Stop and disable first, else the clear is pointless
  task automatic clear_faults();
    wr(ADR_SPEED_DEMAND, 16'h0000);
    wr(ADR_RUN_ENABLE, 16'h0000);
    wr(ADR_FAULT_CLEAR, 16'h0001);
  endtask : clear_faults
endmodule : fieldbus_ctrl

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import compressor_speed_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn;
  logic reg_wr, reg_rd;
  logic [8:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata_q, speed_setpoint_q, stator_power_q;
  logic heating_active_q, running_q, speed_drop_foldback_q, speed_warning_q;
  logic discharge_temp_guard_q, fault_active_q, env_outside, env_grey;
  logic [15:0] nv_min_speed, op_min_speed, out_current, evap_temp, d;
  logic [2:0] subregion;
  logic dlt_config, rd_seen = 1'b0;
  logic [3:0] fault_cause;
  logic [15:0] exp_q[$];
  logic [15:0] heat_tbl [3] = '{16'h000A, 16'h000B, 16'h0064};
  int n_fail = 0, n_checks = 0, cyc = 0, seed = 25, n, t_out;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    subregion <= 3'($unsigned($random(seed)) % 6);
    out_current <= 16'($unsigned($random(seed)) % 256);
  end
  fieldbus_ctrl ctrl (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  compressor_speed_sequencer #(.TICK_CYCLES(1)) dut (.clk_sys(clk_sys),
    .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .nv_min_speed(nv_min_speed), .op_min_speed(op_min_speed),
    .out_current(out_current), .env_outside(env_outside),
    .env_grey(env_grey), .subregion(subregion), .evap_temp(evap_temp),
    .dlt_config(dlt_config), .fault_cause(fault_cause),
    .speed_setpoint_q(speed_setpoint_q), .stator_power_q(stator_power_q),
    .heating_active_q(heating_active_q), .running_q(running_q),
    .speed_drop_foldback_q(speed_drop_foldback_q),
    .speed_warning_q(speed_warning_q),
    .discharge_temp_guard_q(discharge_temp_guard_q),
    .fault_active_q(fault_active_q));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Read data lands one cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_seen && exp_q.size() > 0) chk(reg_rdata_q, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  task automatic rd_chk(input logic [8:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    ctrl.rd(a);
  endtask : rd_chk
  task automatic in_rng(input int v, input int lo, input int hi);
    chk({15'h0000, (v >= lo && v <= hi)}, 16'h0001);
  endtask : in_rng
  task automatic wait_sp(input logic [15:0] t, input int lim, output int k);
    k = 0;
    while (speed_setpoint_q !== t && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= lim) begin
      n_fail++;
      finish_test();
    end
  endtask : wait_sp
  initial begin
    rstn = 1'b0;
    nv_min_speed = 16'h0708;
    op_min_speed = 16'h0800;
    {env_outside, env_grey, dlt_config} = 3'h0;
    evap_temp = 16'h0000;
    fault_cause = 4'h0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd_chk(ADR_PLATFORM, 16'h0E10);
    rd_chk(ADR_HOLD_TIME, 16'h0078);
    rd_chk(ADR_ACCEL, 16'h00C8);
    rd_chk(ADR_DECEL, 16'h00C8);
    rd_chk(ADR_MIN_SPEED, 16'h0708);
    rd_chk(9'h1FF, 16'h0000);
    rd_chk(ADR_HEAT_LIMIT, 16'h0096);
    rd_chk(ADR_ZONE_A, 16'h001E);
    rd_chk(ADR_ZONE_D, 16'hFFF1);
    ctrl.wr(ADR_ACCEL, 16'h0259);
    rd_chk(ADR_ACCEL, 16'h00C8);
    ctrl.wr(ADR_ACCEL, 16'h0258);
    rd_chk(ADR_ACCEL, 16'h0258);
    ctrl.wr(ADR_SHUT_RATE, 16'h001D);
    rd_chk(ADR_SHUT_RATE, 16'h00C8);
    ctrl.wr(ADR_SHUT_RATE, 16'h0190);
    for (int m = 4; m >= 0; m--) begin
      ctrl.wr(ADR_ENV_MODE, 16'(m));
      rd_chk(ADR_ENV_MODE, (m > 3) ? 16'h0000 : 16'(m));
    end
    ctrl.wr(ADR_MIN_SPEED, 16'h0800);
    rd_chk(ADR_MIN_SPEED, 16'h0800);
    ctrl.wr(ADR_ALARM, 16'hFFFF);
    rd_chk(ADR_ALARM, 16'h0000);
    ctrl.wr(ADR_HOLD_TIME, 16'h0001);
    ctrl.wr(ADR_RUN_ENABLE, 16'h0001);
    for (int i = 0; i < 10; i++) begin
      d = (i < 3) ? heat_tbl[i] : 16'($unsigned($random(seed)) % 100 + 1);
      ctrl.wr(ADR_HEAT_DEMAND, d);
      repeat (3) @(posedge clk_sys);
      chk(stator_power_q, (d + 16'h0009) / 16'h000A * 16'h000F);
      chk({15'h0000, heating_active_q}, 16'h0001);
    end
    ctrl.wr(ADR_SPEED_DEMAND, 16'h0FA0);
    repeat (3) @(posedge clk_sys);
    chk({14'h0000, heating_active_q, running_q}, 16'h0001);
    wait_sp(16'h05DC, 3000, n);
    in_rng(n, 2480, 2510);
    wait_sp(16'h0E10, 3000, n);
    in_rng(n, 2090, 2110);
    wait_sp(16'h0FA0, 2000, n);
    in_rng(n, 1655, 1680);
    ctrl.wr(ADR_SPEED_DEMAND, 16'h0000);
    ctrl.wr(ADR_RUN_ENABLE, 16'h0000);
    wait_sp(16'h0E10, 1200, n);
    in_rng(n, 985, 1015);
    wait_sp(16'h0000, 3590, n);
    env_outside <= 1'b1;
    t_out = cyc;
    ctrl.wr(ADR_ENV_MODE, 16'h0003);
    repeat (3) @(posedge clk_sys);
    chk({15'h0000, discharge_temp_guard_q}, 16'h0001);
    ctrl.wr(ADR_SPEED_DEMAND, 16'h07D0);
    ctrl.wr(ADR_RUN_ENABLE, 16'h0001);
    wait_sp(16'h0E10, 5000, n);
    wait_sp(16'h0A28, 8000, n);
    rd_chk(ADR_ALARM, 16'h0000);
    while (cyc - t_out < 15200) @(posedge clk_sys);
    rd_chk(ADR_ALARM, 16'h1000);
    env_outside <= 1'b0;
    ctrl.wr(ADR_RUN_ENABLE, 16'h0000);
    repeat (2) @(posedge clk_sys);
    chk(speed_setpoint_q | 16'(running_q), 16'h0000);
    ctrl.wr(ADR_ENV_MODE, 16'h0000);
    fault_cause <= 4'h1;
    t_out = cyc;
    repeat (3) @(posedge clk_sys);
    chk({15'h0000, fault_active_q}, 16'h0001);
    ctrl.clear_faults();
    rd_chk(ADR_FAULT_CLEAR, 16'h0001);
    fault_cause <= 4'h0;
    while (cyc - t_out < 25000) @(posedge clk_sys);
    chk({15'h0000, fault_active_q}, 16'h0001);
    n = 0;
    while (fault_active_q !== 1'b0 && n < 8000) begin
      @(posedge clk_sys);
      n++;
    end
    in_rng(cyc - t_out, 30000, 31100);
    repeat (2) @(posedge clk_sys);
    rd_chk(ADR_FAULT_CLEAR, 16'h0000);
    repeat (3) @(posedge clk_sys);
    finish_test();
  end
endmodule : tb_top
